// *** inc/sbs_pkg.sv ***
// Package for the shared I/O bus switch: bus line bundles, modes, timing.
// Assumes a single 100 MHz core clock domain; no register bus.
package sbs_pkg;

   // Bus geometry: 27 lines, 8 of them the data byte
   localparam int BUS_LINES  = 27;
   localparam int DATA_W     = 8;
   localparam int CTRL_W     = BUS_LINES - DATA_W;

   // Front-switch input debounce time
   localparam int CLK_PERIOD_NS  = 10;
   localparam int SETTLE_TIME_NS = 1000;
   localparam int SETTLE_CYC     = (SETTLE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int SETTLE_W       = $clog2(SETTLE_CYC + 1);

   // Reset values
   localparam logic RST_REMOTE = 1'b0;
   localparam logic RST_SEL    = 1'b0;

   // Byte-wide bus bundle, data byte plus control lines
   typedef struct packed {
      logic [CTRL_W-1:0] ctrl;
      logic [DATA_W-1:0] data;
   } sbs_bus_t;

   // Switch state
   typedef enum logic [1:0] {
      SBS_LOCAL_OPEN,
      SBS_LOCAL_SEL,
      SBS_REMOTE
   } sbs_mode_t;

   // Status outputs
   typedef struct packed {
      logic remote_mode;
      logic local_sel;
      logic remote_sel;
   } sbs_stat_t;

endpackage : sbs_pkg

// *** rtl/sbs_switch.sv ***
// Shared I/O bus switch: joins a dedicated processor byte bus to a common bus.
// Assumes all inputs synchronous to core_clk; supply-good flags from monitors.
//
// Behaviour
// RQ1: When selected, all 27 dedicated-bus lines pass through to the common bus.
// RQ2: Outside control guarantees at most one switch on a common bus is closed.
// RQ3: When selected, the common bus is spliced into the acknowledge daisy chain.
// RQ4: When unselected, the daisy chain passes straight through on the dedicated bus.
// RQ5: Every transfer across the common bus is a single 8-bit byte.
// RQ6: Traffic is not altered or decoded, only delayed.
// RQ7: Common-bus device addresses differ from all dedicated-bus addresses.
// RQ8: In remote mode the switch is selected while the remote relay input is on.
// RQ9: Relay-driver and logic-level status show mode and local select state.
// RQ10: One front switch enables remote mode, the other makes local selection.
// RQ11: With the negative supply lost, mode changes and local closing are refused.
// RQ12: With the logic supply lost, the switch falls to local, unselected.
// RQ13: An unselected switch drives nothing onto the common bus.
// RQ14: The same logic ties one cycle-stealing channel bus to a shared channel bus.
// RQ15: After reset the switch is unselected with the daisy chain passed through.
`timescale 1ns/1ps

module sbs_switch
   import sbs_pkg::*;
#(
   parameter int SETTLE = SETTLE_CYC
) (
   input  wire logic     core_clk,       // 100 MHz clock
   input  wire logic     resetn,         // Async reset, low active
   input  wire logic     remote_en_sw,   // Front switch: remote enable
   input  wire logic     local_sel_sw,   // Front switch: local select
   input  wire logic     remote_relay,   // Remote select relay energised
   input  wire logic     neg_supply_ok,  // Common-bus negative supply good
   input  wire logic     logic_supply_ok,// Common-bus logic supply good
   input  wire sbs_bus_t ded_bus_i,      // Dedicated (or channel) bus lines in
   input  wire sbs_bus_t com_bus_i,      // Common bus lines back to dedicated
   input  wire logic     ack_in,         // Daisy-chain ack from upstream
   input  wire logic     com_ack_ret,    // Ack returning from end of common bus
   output logic          com_bus_oe,     // Drive enable toward common bus
   output sbs_bus_t      com_bus_o,      // Lines driven onto common bus
   output logic          ded_bus_oe,     // Drive enable back toward dedicated bus
   output sbs_bus_t      ded_bus_o,      // Lines driven back onto dedicated bus
   output logic          com_ack_out,    // Ack sent down the common bus
   output logic          ack_out,        // Ack to rest of dedicated bus
   output sbs_stat_t     stat_logic,     // Logic-level status
   output sbs_stat_t     stat_relay,     // Relay-driver status
   output logic          remote_sel_led  // Remote select indicator
);

   // Debounce counter sized from the parameter, so a long settle time cannot wrap
   localparam int CNT_W = $clog2(SETTLE + 1);

   sbs_mode_t           mode_q, mode_d;
   logic [CNT_W-1:0]    cnt_q, cnt_d;
   logic                rem_raw_q, loc_raw_q;
   logic                rem_sw_q, loc_sw_q;
   logic                raw_change_w, settled_w;
   logic                rem_stable_w, loc_stable_w;
   logic                want_remote_w, want_local_w;
   logic                sel_w;
   sbs_bus_t            com_bus_d, ded_bus_d;
   logic                com_ack_d, ack_d;
   sbs_stat_t           stat_w;
   logic                first_q;

   // Filter front switches: a new level must stay for the settle time;
   // a bouncing contact keeps clearing the counter, so the mode never flickers
   assign raw_change_w = (remote_en_sw != rem_raw_q) || (local_sel_sw != loc_raw_q);
   assign settled_w    = (cnt_q == CNT_W'(SETTLE));
   assign cnt_d        = raw_change_w ? '0
                       : settled_w    ? cnt_q
                       :                cnt_q + CNT_W'(1);
   assign rem_stable_w = settled_w ? rem_raw_q : rem_sw_q;
   assign loc_stable_w = settled_w ? loc_raw_q : loc_sw_q;

   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         rem_raw_q <= 1'b0;
         loc_raw_q <= 1'b0;
         rem_sw_q  <= 1'b0;
         loc_sw_q  <= 1'b0;
         cnt_q     <= '0;
      end else begin
         rem_raw_q <= remote_en_sw;
         loc_raw_q <= local_sel_sw;
         rem_sw_q  <= rem_stable_w;
         loc_sw_q  <= loc_stable_w;
         cnt_q     <= cnt_d;
      end
   end

   assign want_remote_w = rem_sw_q;
   assign want_local_w  = loc_sw_q;

   // Mode decisions; supply losses take priority over the front switches
   always_comb begin
      mode_d = mode_q;
      if (!logic_supply_ok) begin
         mode_d = SBS_LOCAL_OPEN;                             // RQ12
      end else if (!neg_supply_ok) begin
         // Frozen mode; only opening from local select is still allowed
         if (mode_q == SBS_LOCAL_SEL && !want_local_w) begin // RQ11
            mode_d = SBS_LOCAL_OPEN;
         end
      end else begin
         case (mode_q)
            SBS_LOCAL_OPEN: begin
               if (want_remote_w)     mode_d = SBS_REMOTE;   // RQ10
               else if (want_local_w) mode_d = SBS_LOCAL_SEL;// RQ10
            end
            SBS_LOCAL_SEL: begin
               if (want_remote_w)     mode_d = SBS_REMOTE;
               else if (!want_local_w) mode_d = SBS_LOCAL_OPEN;
            end
            SBS_REMOTE: begin
               if (!want_remote_w)
                  mode_d = want_local_w ? SBS_LOCAL_SEL : SBS_LOCAL_OPEN;
            end
            default: mode_d = SBS_LOCAL_OPEN;
         endcase
      end
   end

   // Closed in local select, or in remote mode with the relay on
   assign sel_w = (mode_d == SBS_LOCAL_SEL) ||
                  ((mode_d == SBS_REMOTE) && remote_relay && logic_supply_ok); // RQ8

   // Pass-through selection; an open switch drives zeros both ways, so a failed
   // or unselected processor can never leak onto the shared lines
   assign com_bus_d = sel_w ? ded_bus_i : '0;                  // RQ1 RQ5 RQ6
   assign ded_bus_d = sel_w ? com_bus_i : '0;                  // RQ6 RQ14

   // Daisy chain: spliced through the common bus when closed, straight when open
   assign com_ack_d = sel_w ? ack_in : 1'b0;                   // RQ3
   assign ack_d     = sel_w ? com_ack_ret : ack_in;            // RQ3 RQ4

   // Mode register; comes up open so no processor owns the shared bus
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         mode_q <= SBS_LOCAL_OPEN;                             // RQ15
      end else begin
         mode_q <= mode_d;
      end
   end

   // Drive enables; both directions open and close on the same edge
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         com_bus_oe <= RST_SEL;
         ded_bus_oe <= RST_SEL;
      end else begin
         com_bus_oe <= sel_w;                                  // RQ13
         ded_bus_oe <= sel_w;                                  // RQ14
      end
   end

   // Data and control lines, one cycle of delay each way, nothing decoded
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         com_bus_o <= '0;
         ded_bus_o <= '0;
      end else begin
         com_bus_o <= com_bus_d;
         ded_bus_o <= ded_bus_d;
      end
   end

   // Acknowledge chain; registering it costs one cycle but keeps outputs clean
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         com_ack_out <= 1'b0;
         ack_out     <= 1'b0;
      end else begin
         com_ack_out <= com_ack_d;
         ack_out     <= ack_d;
      end
   end

   // Status flags; one set feeds both the logic-level and relay-driver copies
   assign stat_w = '{
      remote_mode: (mode_d == SBS_REMOTE),
      local_sel:   (mode_d == SBS_LOCAL_SEL),
      remote_sel:  (mode_d == SBS_REMOTE) && remote_relay && logic_supply_ok
   };

   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         stat_logic     <= '{RST_REMOTE, RST_SEL, RST_SEL};
         stat_relay     <= '{RST_REMOTE, RST_SEL, RST_SEL};
         remote_sel_led <= 1'b0;
      end else begin
         stat_logic     <= stat_w;                             // RQ9
         stat_relay     <= stat_w;                             // RQ9
         remote_sel_led <= stat_w.remote_sel;                  // RQ10
      end
   end

   // Marks the first edge after reset release, for the power-up check only
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         first_q <= 1'b1;
      end else begin
         first_q <= 1'b0;
      end
   end

   // Checks
   // Logic supply loss forces the switch open and local
   chk_logic_loss_open: assert property (@(posedge core_clk) disable iff (!resetn) // RQ12
      !logic_supply_ok |=> !com_bus_oe && !stat_logic.remote_mode
                           && !stat_logic.local_sel)
      else $error("switch not opened on logic supply loss");
   // Indicator, return drive and common-bus ack drop with the logic supply too
   chk_logic_loss_led: assert property (@(posedge core_clk) disable iff (!resetn) // RQ12
      !logic_supply_ok |=> !remote_sel_led && !ded_bus_oe && !com_ack_out)
      else $error("outputs still active on logic supply loss");

   // Negative supply loss freezes the mode, except for opening a local select
   chk_neg_no_close: assert property (@(posedge core_clk) disable iff (!resetn) // RQ11
      (!neg_supply_ok && logic_supply_ok && mode_q == SBS_LOCAL_OPEN)
         |=> mode_q == SBS_LOCAL_OPEN)
      else $error("mode changed with negative supply lost");
   // Remote control keeps its mode while the negative supply is away
   chk_neg_keep_remote: assert property (@(posedge core_clk) disable iff (!resetn) // RQ11
      (!neg_supply_ok && logic_supply_ok && mode_q == SBS_REMOTE)
         |=> mode_q == SBS_REMOTE)
      else $error("remote mode lost on negative supply loss");
   // A local select may not turn into remote mode without the negative supply
   chk_neg_no_remote: assert property (@(posedge core_clk) disable iff (!resetn) // RQ11
      (!neg_supply_ok && logic_supply_ok && mode_q == SBS_LOCAL_SEL)
         |=> mode_q != SBS_REMOTE)
      else $error("local select moved to remote with negative supply lost");

   // Forward path copies the dedicated lines unchanged
   chk_pass_data: assert property (@(posedge core_clk) disable iff (!resetn) // RQ1
      sel_w |=> com_bus_oe && com_bus_o == $past(ded_bus_i))
      else $error("data not passed through when selected");
   // Return path mirrors the forward path
   chk_pass_back: assert property (@(posedge core_clk) disable iff (!resetn) // RQ6
      sel_w |=> ded_bus_oe && ded_bus_o == $past(com_bus_i))
      else $error("common bus lines not returned when selected");
   // An open switch leaves the common bus alone
   chk_open_quiet: assert property (@(posedge core_clk) disable iff (!resetn) // RQ13
      !sel_w |=> !com_bus_oe && com_bus_o == '0)
      else $error("common bus driven while open");
   // No acknowledge enters the common bus while it is not driven
   chk_com_ack_quiet: assert property (@(posedge core_clk) disable iff (!resetn) // RQ13
      !com_bus_oe |-> !com_ack_out)
      else $error("acknowledge sent down an undriven common bus");
   // An open switch returns nothing toward the dedicated or channel bus
   chk_back_quiet: assert property (@(posedge core_clk) disable iff (!resetn) // RQ14
      !sel_w |=> !ded_bus_oe && ded_bus_o == '0)
      else $error("dedicated bus driven while open");
   // Both directions always switch together
   chk_oe_pair: assert property (@(posedge core_clk) disable iff (!resetn) // RQ14
      com_bus_oe == ded_bus_oe)
      else $error("drive enables disagree");

   // Daisy chain, open and closed
   chk_chain_through: assert property (@(posedge core_clk) disable iff (!resetn) // RQ4
      !sel_w |=> ack_out == $past(ack_in) && !com_ack_out)
      else $error("daisy chain broken while open");
   // Closed switch puts the common bus inside the chain
   chk_chain_splice: assert property (@(posedge core_clk) disable iff (!resetn) // RQ3
      sel_w |=> ack_out == $past(com_ack_ret) && com_ack_out == $past(ack_in))
      else $error("common bus not in daisy chain");

   // Remote relay closes the switch in remote mode
   chk_remote_select: assert property (@(posedge core_clk) disable iff (!resetn) // RQ8
      (mode_q == SBS_REMOTE && mode_d == SBS_REMOTE && remote_relay && logic_supply_ok)
         |=> com_bus_oe && remote_sel_led)
      else $error("remote relay did not select");
   // Without the relay, remote mode stays open
   chk_remote_open: assert property (@(posedge core_clk) disable iff (!resetn) // RQ8
      (mode_d == SBS_REMOTE && !remote_relay) |=> !com_bus_oe && !com_ack_out)
      else $error("remote mode closed without the relay");
   // Remote select flag and indicator need the relay
   chk_relay_needed: assert property (@(posedge core_clk) disable iff (!resetn) // RQ8
      !remote_relay |=> !stat_logic.remote_sel && !remote_sel_led)
      else $error("remote select shown without the relay");

   // Front switches: local select closes from open, remote enable wins
   chk_local_close: assert property (@(posedge core_clk) disable iff (!resetn) // RQ10
      (logic_supply_ok && neg_supply_ok && mode_q == SBS_LOCAL_OPEN
         && want_local_w && !want_remote_w) |=> com_bus_oe && stat_logic.local_sel)
      else $error("local select switch did not close");
   // With both supplies good, remote enable takes the switch to remote mode
   chk_remote_wins: assert property (@(posedge core_clk) disable iff (!resetn) // RQ10
      (logic_supply_ok && neg_supply_ok && want_remote_w)
         |=> stat_logic.remote_mode && !stat_logic.local_sel)
      else $error("remote enable switch not obeyed");

   // Status copies agree and follow the mode
   chk_status_mode: assert property (@(posedge core_clk) disable iff (!resetn) // RQ9
      ##1 stat_relay == stat_logic && stat_logic.remote_mode == (mode_q == SBS_REMOTE))
      else $error("status does not match mode");
   // Local select is only shown in local mode
   chk_local_status: assert property (@(posedge core_clk) disable iff (!resetn) // RQ9
      stat_logic.local_sel |-> !stat_logic.remote_mode && !stat_logic.remote_sel)
      else $error("local select shown outside local mode");

   // Power-up leaves the switch open and local
   chk_reset_open: assert property (@(posedge core_clk) disable iff (!resetn) // RQ15
      first_q |-> !com_bus_oe && !ded_bus_oe && stat_logic == '0
                  && mode_q == SBS_LOCAL_OPEN)
      else $error("switch not open after reset");

endmodule : sbs_switch

// *** tb/sbs_far_model.sv ***
// Far-side model: the common-bus controllers that answer through the switch.
// Assumes the switch drives the common bus only while com_bus_oe is high.
`timescale 1ns/1ps
module sbs_far_model
   import sbs_pkg::*;
(
   input  wire logic     core_clk,    // Clock
   input  wire logic     com_bus_oe,  // Switch drives common bus
   input  wire logic     com_ack_out, // Ack entering common bus
   input  wire logic     pend,        // A controller holds an interrupt
   input  wire sbs_bus_t resp,        // Lines the controllers return
   output sbs_bus_t      com_bus_i,   // Common bus lines back to switch
   output logic          com_ack_ret  // Ack leaving end of common bus
);
   logic flip_q = 1'b0;
   // Released bus toggles so stale data can never look valid
   always @(posedge core_clk) flip_q <= ~flip_q;
   assign com_bus_i   = com_bus_oe ? resp : sbs_bus_t'({BUS_LINES{flip_q}});
   // Controllers here answer only addresses unused on any dedicated bus
   // A controller with a pending interrupt absorbs the ack
   assign com_ack_ret = com_ack_out & ~pend;
endmodule : sbs_far_model

// *** tb/tb.sv ***
// Testbench for the shared bus switch: modes, supplies, pass-through, daisy chain.
// Assumes SETTLE of 2, so a front switch is seen within 5 edges.
`timescale 1ns/1ps
module tb
   import sbs_pkg::*;
;
   logic      core_clk = 0, resetn = 0, ren = 0, lsel = 0, relay = 0;
   logic      nok = 1, lok = 1, ack_in = 0, pend = 0;
   logic      com_oe, ded_oe, com_ack, ack_out, ack_ret, led;
   sbs_bus_t  ded_i = '0, resp = '0, com_i, com_o, ded_o;
   sbs_stat_t st_l, st_r;
   int        failures = 0, check_count = 0;
   logic [26:0] pat [4] = '{27'h7ffffff, 27'h0000000, 27'h5a5a5a5, 27'h1234567};

   always #5 core_clk = ~core_clk;

   sbs_switch #(.SETTLE(2)) DUT (.core_clk(core_clk), .resetn(resetn), .remote_en_sw(ren),
      .local_sel_sw(lsel), .remote_relay(relay), .neg_supply_ok(nok),
      .logic_supply_ok(lok), .ded_bus_i(ded_i), .com_bus_i(com_i), .ack_in(ack_in),
      .com_ack_ret(ack_ret), .com_bus_oe(com_oe), .com_bus_o(com_o), .ded_bus_oe(ded_oe),
      .ded_bus_o(ded_o), .com_ack_out(com_ack), .ack_out(ack_out), .stat_logic(st_l),
      .stat_relay(st_r), .remote_sel_led(led));

   sbs_far_model far (.core_clk(core_clk), .com_bus_oe(com_oe), .com_ack_out(com_ack),
      .pend(pend), .resp(resp), .com_bus_i(com_i), .com_ack_ret(ack_ret));

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         failures++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   // Inputs change and outputs are judged at the falling edge
   task automatic step(input int n);
      repeat (n) @(negedge core_clk);
   endtask : step

   task automatic stat(input logic [2:0] e, input logic oe);
      chk(st_l, e);
      chk(st_r, e);
      chk(com_oe, oe);
      chk(ded_oe, oe);
   endtask : stat

   task automatic end_of_test;
      $display("checks=%0d failures=%0d", check_count, failures);
      if (failures == 0 && check_count > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask : end_of_test

   task automatic t_local;
      lsel = 1;
      step(8);
      stat(3'b010, 1);
      foreach (pat[i]) begin
         ded_i = pat[i];
         resp  = ~pat[i];
         step(1);
         chk(com_o, pat[i]);
         chk(ded_o, {5'h00, ~pat[i]});
      end
      ack_in = 1;
      step(2);
      chk(com_ack, 1);
      chk(ack_out, 1);
      pend = 1;
      step(2);
      chk(ack_out, 0);
   endtask : t_local

   task automatic t_neg;
      nok  = 0;
      lsel = 0;
      step(8);
      stat(3'b000, 0);
      lsel = 1;
      ren  = 1;
      ded_i = pat[0];
      step(8);
      stat(3'b000, 0);
      chk(ack_out, 1);
      chk(com_ack, 0);
      chk(com_o, 0);
      ren  = 0;
      lsel = 0;
      step(8);
      nok  = 1;   // Supply back only once the filtered switches read open
      step(2);
      stat(3'b000, 0);
   endtask : t_neg

   task automatic t_remote;
      ren = 1;
      step(8);
      stat(3'b100, 0);
      relay = 1;
      step(2);
      stat(3'b101, 1);
      chk(led, 1);
      nok   = 0;
      relay = 0;
      step(2);
      stat(3'b100, 0);
      relay = 1;
      step(2);
      stat(3'b101, 1);
      nok = 1;
      lok = 0;
      step(2);
      stat(3'b000, 0);
      chk(led, 0);
      ren   = 0;
      relay = 0;
      step(8);
      lok  = 1;
      lsel = 1;
      step(8);
      stat(3'b010, 1);
   endtask : t_remote

   initial begin
      step(11);
      stat(3'b000, 0);
      chk(ack_out, 0);
      step(1);
      resetn = 1;
      ack_in = 1;
      step(2);
      chk(ack_out, 1);
      t_local();
      t_neg();
      t_remote();
      end_of_test();
   end

   // Whole run is under a hundred cycles; this cuts a hang short
   initial begin
      #50000;
      failures++;
      end_of_test();
   end
endmodule : tb
